/* cbg_core.sv */
// Processor side of the bus grant handshake and the basic single bus cycle.
`timescale 1ns/100ps
module cbg_core
	import cbg_pkg::*;
(
	input  wire logic              ref_clk_in,        // 25 MHz bus clock.
	input  wire logic              rst_b_in,          // Asynchronous reset, active low.
	// Core side request port.
	input  wire logic              req_valid_in,      // Core has a transfer pending.
	input  wire cbg_req_t          req_in,            // Cycle definition and data.
	output logic                   req_ready_out,     // Request taken this clock.
	output logic                   rsp_valid_out,     // Cycle completed, one clock pulse.
	output logic [DATA_W-1:0]      rsp_rdata_out,     // Read data of the finished cycle.
	// Arbitration pins.
	input  wire logic              bus_release_req_in,// Other master wants the bus.
	output logic                   bus_release_ack_out,// Bus given up.
	output logic                   bus_want_request_out,// Core has pending bus activity.
	// Bus cycle pins.
	output logic                   addr_strobe_n_out, // Start of cycle, active low.
	output logic [ADDR_W-1:0]      addr_out,          // Address lines.
	output logic [BE_W-1:0]        be_n_out,          // Byte enables, active low.
	output logic                   write_out,         // Write, high; read, low.
	output logic                   mem_io_out,        // Memory, high; I/O, low.
	output logic                   data_code_out,     // Data, high; code, low.
	output logic                   status_oe_n_out,   // Address and status enable, low drives.
	output logic [DATA_W-1:0]      data_out,          // Data lines out.
	output logic                   data_oe_n_out,     // Data enable, low drives.
	input  wire logic [DATA_W-1:0] data_in,           // Data lines in.
	input  wire logic              dpar_in,           // Even parity over data, one bit.
	input  wire logic              ready_n_in,        // Non-burst ready, active low.
	input  wire logic              burst_ready_n_in,  // Burst ready, active low.
	output logic                   last_transfer_n_out,// Last transfer, active low.
	output logic                   parity_check_n_out // Parity error, active low.
);

	////////////////////////////////////////////////////////////////////////////////////
	// State and registers.

	cbg_state_t        state_q, state_d;          // Bus state.
	cbg_req_t          cyc_q;                     // Latched cycle definition.
	logic [DATA_W-1:0] rdata_q;                   // Captured read data.
	logic              rsp_q;                     // Completion pulse.
	logic              parity_check_n_q;                    // Parity check output register.

	// Either ready ends a single cycle; burst ready acts as ready here.
	wire done_w     = (state_q == CBG_T2) && (!ready_n_in || !burst_ready_n_in);
	wire start_w    = (state_q == CBG_IDLE) && req_valid_in && !bus_release_req_in;
	wire release_w  = (state_q == CBG_IDLE) && bus_release_req_in;
	wire read_end_w = done_w && !cyc_q.write;
	wire par_bad_w  = ^{data_in, dpar_in};                                          // Odd sum is an error.

	////////////////////////////////////////////////////////////////////////////////////
	// Next state: a cycle always passes T1 then at least one T2, so it is two clocks or more.

	always_comb begin
		state_d = state_q;
		case (state_q)
			CBG_IDLE: begin
				if (release_w) begin
					state_d = CBG_HELD;
				end else if (start_w) begin
					state_d = CBG_T1;
				end
			end
			CBG_T1: begin
				state_d = CBG_T2;                              // ready ignored in T1.
			end
			CBG_T2: begin
				if (done_w) begin
					state_d = CBG_IDLE;
				end
			end
			CBG_HELD: begin
				if (!bus_release_req_in) begin
					state_d = CBG_IDLE;
				end
			end
			default: begin
				state_d = CBG_IDLE;
			end
		endcase
	end

	// State register; reset leaves the processor as bus owner.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= CBG_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Latch the cycle definition when the cycle starts, so it stays stable throughout.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cyc_q <= '{write: 1'b0, mem_io: 1'b0, data_code: 1'b0,
				be_n: BE_RST, addr: ADDR_RST, wdata: DATA_RST};
		end else if (start_w) begin
			cyc_q <= req_in;
		end
	end

	// Read data, completion pulse and parity result, each registered.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_q <= DATA_RST;
			rsp_q   <= 1'b0;
			parity_check_n_q  <= 1'b1;
		end else begin
			rsp_q  <= done_w;
			parity_check_n_q <= !(read_end_w && par_bad_w);
			if (read_end_w) begin
				rdata_q <= data_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Outputs. Strobe is decoded from the T1 state; definition comes from the latched cycle.

	wire owns_w = (state_q != CBG_HELD);                      // Processor owns the bus.

	assign req_ready_out        = start_w;
	assign rsp_valid_out        = rsp_q;
	assign rsp_rdata_out        = rdata_q;
	assign bus_release_ack_out  = (state_q == CBG_HELD);
	assign bus_want_request_out = req_valid_in || (state_q == CBG_T1)
		|| (state_q == CBG_T2);
	assign addr_strobe_n_out    = !(state_q == CBG_T1);
	assign addr_out             = cyc_q.addr;
	assign be_n_out             = cyc_q.be_n;
	assign write_out            = cyc_q.write;
	assign mem_io_out           = cyc_q.mem_io;
	assign data_code_out        = cyc_q.data_code;
	assign status_oe_n_out      = !owns_w;
	assign data_out             = cyc_q.wdata;
	// Data lines drive only in a write cycle; a read leaves them to the memory.
	assign data_oe_n_out        = !(owns_w && cyc_q.write && (state_q != CBG_IDLE));
	// Single cycles are always the last transfer, shown low in T2.
	assign last_transfer_n_out  = !(state_q == CBG_T2);
	assign parity_check_n_out   = parity_check_n_q;

	////////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_ack_idle;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		$rose(bus_release_ack_out) |-> $past(state_q) == CBG_IDLE && $past(bus_release_req_in);
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("Ack raised outside idle.");

	property p_no_start_held;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		bus_release_req_in || bus_release_ack_out |-> !req_ready_out;
	endproperty
	a_no_start_held: assert property (p_no_start_held) else $error("Cycle started while held.");

	property p_float;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		bus_release_ack_out |-> status_oe_n_out && data_oe_n_out && addr_strobe_n_out;
	endproperty
	a_float: assert property (p_float) else $error("Driving bus while released.");

	property p_min_two;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!addr_strobe_n_out |=> !last_transfer_n_out;
	endproperty
	a_min_two: assert property (p_min_two) else $error("Cycle shorter than two clocks.");

	property p_strobe_start;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		req_ready_out |=> !addr_strobe_n_out && addr_out == $past(req_in.addr);
	endproperty
	a_strobe_start: assert property (p_strobe_start) else $error("Strobe or address wrong.");

	property p_ignore_t1;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!addr_strobe_n_out |=> !rsp_valid_out;
	endproperty
	a_ignore_t1: assert property (p_ignore_t1) else $error("Completed on first clock.");

	property p_wait;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!last_transfer_n_out && ready_n_in && burst_ready_n_in |=> !last_transfer_n_out;
	endproperty
	a_wait: assert property (p_wait) else $error("Wait state not honoured.");

	property p_parity_check_n;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!last_transfer_n_out && !ready_n_in && !write_out && par_bad_w
		|=> !parity_check_n_out ##1 parity_check_n_out;
	endproperty
	a_parity_check_n: assert property (p_parity_check_n) else $error("Parity check timing wrong.");

	property p_want;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		req_valid_in |-> bus_want_request_out;
	endproperty
	a_want: assert property (p_want) else $error("Bus request missing.");

	// The strobe clock is never the last clock, because the last-transfer flag waits for T2.
	property p_last_t1;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!addr_strobe_n_out |-> last_transfer_n_out;
	endproperty
	a_last_t1: assert property (p_last_t1) else $error("Last low in first clock.");

	// Once given up, the bus stays released for as long as the other master asks for it.
	property p_ack_hold;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		bus_release_ack_out && bus_release_req_in |=> bus_release_ack_out;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("Ack dropped too early.");

	// The bus comes back one clock after the request is removed, with the pins driven again.
	property p_take_back;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		bus_release_ack_out && !bus_release_req_in |=> !bus_release_ack_out && !status_oe_n_out;
	endproperty
	a_take_back: assert property (p_take_back) else $error("Bus not taken back.");

	// A parity error may only be flagged in the clock after a read ended in T2.
	property p_parity_check_n_read;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!parity_check_n_out |-> !$past(last_transfer_n_out) && !$past(write_out);
	endproperty
	a_parity_check_n_read: assert property (p_parity_check_n_read) else $error("Parity flag without a read.");

	// Data lines drive only for a write, and only while the processor owns the bus.
	property p_data_write;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!data_oe_n_out |-> write_out && !status_oe_n_out;
	endproperty
	a_data_write: assert property (p_data_write) else $error("Data driven outside a write.");

endmodule

/* cbg_mem_model.sv */
// Behavioural memory and ready source on the far side of the processor bus.
`timescale 1ns/100ps
module cbg_mem_model (
	input  wire logic        clk_in,       // Bus clock.
	input  wire logic        rst_b_in,     // Reset, active low.
	input  wire logic        strobe_n_in,  // Address strobe from the core.
	input  wire logic        write_in,     // Cycle direction.
	input  wire logic [31:0] wdata_in,     // Write data from the core.
	input  wire logic [3:0]  waits_in,     // Wait states to insert.
	input  wire logic        bad_par_in,   // Flip the parity bit on purpose.
	input  wire logic [31:0] rd_val_in,    // Value returned by reads.
	output logic [31:0]      data_out,     // Read data lines.
	output logic             dpar_out,     // Parity line.
	output logic             ready_n_out,  // Non-burst ready, active low.
	output logic             burst_ready_n_out, // Burst ready, never used.
	output logic [31:0]      last_wr_out   // Last write taken.
);
	logic       busy_q;  // A cycle is past its first clock.
	logic [3:0] cnt_q;   // Clocks spent in T2 so far.
	// Waits are held off by keeping ready high until the count is met.
	assign ready_n_out = !(busy_q && cnt_q >= waits_in);
	// Lines carry the inverse outside the data clock, so stale data cannot pass.
	assign data_out = ready_n_out ? ~rd_val_in : rd_val_in;
	assign dpar_out = ready_n_out ? 1'b0 : (^data_out) ^ bad_par_in;
	assign burst_ready_n_out = 1'b1;
	// Track the cycle from strobe to ready and capture writes at ready.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_q <= 1'b0;
			cnt_q  <= 4'h0;
			last_wr_out <= 32'h0000_0000;
		end else if (!strobe_n_in) begin
			busy_q <= 1'b1;
			cnt_q  <= 4'h0;
		end else if (busy_q && !ready_n_out) begin
			busy_q <= 1'b0;
			if (write_in) begin
				last_wr_out <= wdata_in;
			end
		end else if (busy_q) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

/* cbg_pkg.sv */
// Package of constants and carrier types for the processor bus grant and single cycle block.
// How it works
// - Acknowledge release only when bus is idle.
// - Raise bus request while activity is pending.
// - Take bus only without release request.
// - Float address, data, status when not owner.
// - Cycle lasts two clocks at least.
// - Strobe address with valid definition first clock.
// - Sample ready from second clock; ignore first.
// - Drive last transfer low in T2.
// - Parity check output one clock after read.
package cbg_pkg;
	localparam int ADDR_W = 32;                 // Address width.
	localparam int DATA_W = 32;                 // Data bus width.
	localparam int BE_W   = 4;                  // Byte enable width.
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;  // Reset value of data registers.
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;  // Reset value of the address.
	localparam logic [BE_W-1:0]   BE_RST   = 4'h0;           // Reset value of byte enables.

	// Cycle definition carried with each request.
	typedef struct packed {
		logic              write;      // High for a write cycle.
		logic              mem_io;     // High for memory, low for I/O.
		logic              data_code;  // High for data, low for code.
		logic [BE_W-1:0]   be_n;       // Byte enables, active low.
		logic [ADDR_W-1:0] addr;       // Byte address.
		logic [DATA_W-1:0] wdata;      // Write data.
	} cbg_req_t;

	// Bus states of the single cycle engine.
	typedef enum logic [1:0] {
		CBG_IDLE,    // Bus owned and quiet, no cycle running.
		CBG_T1,      // First clock, address strobe out.
		CBG_T2,      // Second and wait clocks.
		CBG_HELD     // Bus released to another master.
	} cbg_state_t;
endpackage

/* testbench.sv */
// Self-checking testbench of the bus grant and single cycle block.
`timescale 1ns/100ps
module testbench;
	import cbg_pkg::*;
	logic ref_clk_in = 1'b0;  // Bus clock.
	logic rst_b_in = 1'b0;    // Reset, active low.
	logic req_valid = 1'b0;   // Core request.
	cbg_req_t req = '0;       // Cycle definition.
	logic rel_req = 1'b0;     // Other master wants the bus; idle after reset.
	logic [3:0] waits = 4'h0; // Wait states of the next cycle.
	logic bad_par = 1'b0;     // Corrupt parity of the next read.
	logic [31:0] rd_val = 32'h0000_0000; // Read value.
	logic req_ready_out, rsp_valid_out, bus_release_ack_out, bus_want_request_out;
	logic addr_strobe_n_out, write_out, status_oe_n_out, data_oe_n_out;
	logic last_transfer_n_out, parity_check_n_out, dpar, ready_n, bready_n;
	logic [31:0] rsp_rdata_out, addr_out, data_out, data_in, last_wr;
	logic mem_io_out, data_code_out; // Cycle definition bits.
	logic [3:0] be_n_out;            // Byte enables, active low.
	int n_errors = 0;
	int compares = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	cbg_core dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid),
		.req_in(req), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_rdata_out(rsp_rdata_out), .bus_release_req_in(rel_req),
		.bus_release_ack_out(bus_release_ack_out), .bus_want_request_out(bus_want_request_out),
		.addr_strobe_n_out(addr_strobe_n_out), .addr_out(addr_out), .be_n_out(be_n_out),
		.write_out(write_out), .mem_io_out(mem_io_out), .data_code_out(data_code_out),
		.status_oe_n_out(status_oe_n_out),
		.data_out(data_out), .data_oe_n_out(data_oe_n_out), .data_in(data_in), .dpar_in(dpar),
		.ready_n_in(ready_n), .burst_ready_n_in(bready_n),
		.last_transfer_n_out(last_transfer_n_out), .parity_check_n_out(parity_check_n_out));
	cbg_mem_model mem (.clk_in(ref_clk_in), .rst_b_in(rst_b_in), .strobe_n_in(addr_strobe_n_out),
		.write_in(write_out), .wdata_in(data_out), .waits_in(waits), .bad_par_in(bad_par),
		.rd_val_in(rd_val), .data_out(data_in), .dpar_out(dpar), .ready_n_out(ready_n),
		.burst_ready_n_out(bready_n), .last_wr_out(last_wr));
	////////////////////////////////////////////////////////////////////////////////
	// Case-equal compare so that an unknown never counts as a match.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// One single cycle, read or write, with a given wait count.
	task automatic do_cycle(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] wt, input logic bp);
		int n;
		@(negedge ref_clk_in);
		waits = wt;
		bad_par = bp;
		rd_val = d;
		// Definition bits and byte enables follow the stimulus, so each of them is seen to move.
		req = '{write: w, mem_io: a[13], data_code: a[12], be_n: d[3:0], addr: a,
			wdata: d};
		req_valid = 1'b1;
		// Let the combinational request outputs settle before they are looked at.
		#1;
		chk(bus_want_request_out, 1'b1, "want");
		n = 0;
		while (!req_ready_out && n < 50) begin
			@(negedge ref_clk_in);
			n++;
		end
		chk(req_ready_out, 1'b1, "taken");
		@(negedge ref_clk_in);
		req_valid = 1'b0;
		chk(addr_strobe_n_out, 1'b0, "strobe t1");
		chk(addr_out, a, "addr");
		chk(write_out, w, "write def");
		chk(mem_io_out, a[13], "mem io");
		chk(data_code_out, a[12], "data code");
		chk(be_n_out, d[3:0], "byte enables");
		chk(last_transfer_n_out, 1'b1, "last t1");
		@(negedge ref_clk_in);
		chk(addr_strobe_n_out, 1'b1, "strobe t2");
		chk(last_transfer_n_out, 1'b0, "last t2");
		chk(data_oe_n_out, !w, "drive");
		n = 0;
		while (!rsp_valid_out && n < 50) begin
			@(negedge ref_clk_in);
			n++;
		end
		chk(n, wt + 1, "length");
		if (w) chk(last_wr, d, "write");
		else begin
			chk(rsp_rdata_out, d, "read");
			chk(parity_check_n_out, !bp, "parity");
		end
	endtask
	// Release the bus to another master, and take it back. The bench is the arbiter with
	// one other master only, so requests are served one at a time, on demand, never sliced.
	task automatic do_release;
		int n;
		@(negedge ref_clk_in);
		rel_req = 1'b1;
		req_valid = 1'b1;
		n = 0;
		// The other master is granted only once the processor has let go.
		while (!bus_release_ack_out && n < 10) begin
			@(negedge ref_clk_in);
			n++;
		end
		chk(n, 1, "ack delay");
		// The other master keeps the bus for a few clocks while the processor waits.
		repeat (3) @(negedge ref_clk_in);
		chk(bus_release_ack_out, 1'b1, "ack");
		chk(status_oe_n_out, 1'b1, "float");
		chk(data_oe_n_out, 1'b1, "data float");
		chk(addr_strobe_n_out, 1'b1, "no strobe held");
		chk(req_ready_out, 1'b0, "held");
		chk(bus_want_request_out, 1'b1, "want held");
		rel_req = 1'b0;
		req_valid = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		chk(bus_release_ack_out, 1'b0, "ack off");
		chk(status_oe_n_out, 1'b0, "owns");
	endtask
	// A release request that arrives in mid-cycle waits until that cycle has ended.
	task automatic do_release_busy;
		int n;
		@(negedge ref_clk_in);
		waits = 4'h2;
		bad_par = 1'b0;
		rd_val = 32'h5A5A_C3C3;
		req = '{write: 1'b0, mem_io: 1'b1, data_code: 1'b0, be_n: 4'h0,
			addr: 32'h0000_4010, wdata: 32'h0000_0000};
		req_valid = 1'b1;
		#1;
		chk(req_ready_out, 1'b1, "busy taken");
		@(negedge ref_clk_in);
		req_valid = 1'b0;
		rel_req = 1'b1;
		chk(addr_strobe_n_out, 1'b0, "busy t1");
		n = 0;
		// Counted from T1: one strobe clock, then one T2 per wait and one for ready.
		while (!rsp_valid_out && n < 20) begin
			@(negedge ref_clk_in);
			chk(bus_release_ack_out, 1'b0, "ack in cycle");
			n++;
		end
		chk(n, 4, "busy length");
		chk(rsp_rdata_out, 32'h5A5A_C3C3, "busy read");
		@(negedge ref_clk_in);
		chk(bus_release_ack_out, 1'b1, "ack after");
		chk(status_oe_n_out, 1'b1, "float after");
		rel_req = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		chk(bus_release_ack_out, 1'b0, "ack off after");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge ref_clk_in);
		chk(status_oe_n_out, 1'b0, "reset owner");
		chk(addr_strobe_n_out, 1'b1, "reset strobe");
		rst_b_in = 1'b1;
		do_cycle(1'b0, 32'h0000_1000, 32'h1234_5678, 4'h0, 1'b0);
		do_cycle(1'b1, 32'h0000_2004, 32'hA5A5_0F0F, 4'h3, 1'b0);
		do_cycle(1'b0, 32'h0000_3008, 32'h0000_00FF, 4'h1, 1'b1);
		do_release;
		do_release_busy;
		do_cycle(1'b0, 32'hFFFF_FFFC, 32'hFFFF_0000, 4'h2, 1'b0);
		wrap_up;
	end
	// Watchdog well beyond the few dozen clocks the scenarios need.
	initial begin
		#100000;
		n_errors++;
		wrap_up;
	end
endmodule
